// ===== rtl/autoconfig_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module autoconfig_sequencer
  import misc_cfg_pkg::*;
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // eeprom read completion
  input  wire logic eeprom_done_i,
  input  wire logic eeprom_cksum_ok_i,
  input  wire logic activate_i,
  // resulting state
  output logic      active_o,
  output logic      alternate_o
);

  autoconfig_state_t state_q;  // current state
  autoconfig_state_t state_d;  // next state

  // decide the outcome once the serial eeprom read ends
  always_comb begin
    state_d = state_q;
    case (state_q)
      AC_WAIT: begin
        if (eeprom_done_i) begin
          if (!eeprom_cksum_ok_i) begin
            state_d = AC_ALTERNATE;
          end else if (activate_i) begin
            state_d = AC_ACTIVE;
          end else begin
            state_d = AC_INACTIVE;
          end
        end
      end
      AC_INACTIVE: state_d = AC_INACTIVE;
      AC_ACTIVE:   state_d = AC_ACTIVE;
      AC_ALTERNATE: state_d = AC_ALTERNATE;
      default:     state_d = AC_WAIT;
    endcase
  end

  // state register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= AC_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // decoded flags
  assign active_o    = (state_q == AC_ACTIVE);
  assign alternate_o = (state_q == AC_ALTERNATE);

endmodule
`default_nettype wire

// ===== rtl/config_write_gate.sv
`timescale 1ns/1ps
`default_nettype none
module config_write_gate
  import misc_cfg_pkg::*;
(
  // index and strobes
  input  wire logic [IDX_W-1:0]   index_i,
  input  wire logic               data_wr_i,
  input  wire logic               sw_reset_rd_i,
  // guard state
  input  wire logic               guard_i,
  // gated results
  output logic [NUM_CFG-1:0]      wr_en_o,
  output logic                    soft_clear_o
);

  // per-register write enables; guarded entries drop writes
  always_comb begin
    wr_en_o = '0;
    if (data_wr_i && in_bank(index_i)) begin
      if (index_i == IDX_EECFG) begin
        // eeprom configuration lives elsewhere
        wr_en_o = '0;
      end else if (!guard_i) begin
        wr_en_o[index_i[2:0]] = 1'b1;
      end else begin
        wr_en_o = '0;
      end
    end
  end

  // software reset read restores the bank defaults only while unguarded
  always_comb begin
    soft_clear_o = sw_reset_rd_i && !guard_i;
  end

endmodule
`default_nettype wire

// ===== rtl/misc_cfg_pkg.sv
package misc_cfg_pkg;

  // register index port width and the indices of this bank
  localparam int unsigned IDX_W          = 7;
  localparam logic [6:0]  IDX_CFG_LAST   = 7'h07;
  localparam logic [6:0]  IDX_MSRDA      = 7'h00;
  localparam logic [6:0]  IDX_MSWRA      = 7'h01;
  localparam logic [6:0]  IDX_MISC       = 7'h02;
  localparam logic [6:0]  IDX_EECFG      = 7'h03;
  localparam logic [6:0]  IDX_LED0       = 7'h04;
  localparam logic [6:0]  IDX_LED1       = 7'h05;
  localparam logic [6:0]  IDX_LED2       = 7'h06;
  localparam logic [6:0]  IDX_LED3       = 7'h07;
  localparam int unsigned NUM_CFG        = 8;

  // reset values of the bank
  localparam logic [15:0] RST_MSRDA      = 16'h0005;
  localparam logic [15:0] RST_MSWRA      = 16'h0005;
  localparam logic [15:0] RST_MISC       = 16'h0002;
  localparam logic [15:0] RST_LED0       = 16'h0000;
  localparam logic [15:0] RST_LED1       = 16'h0084;
  localparam logic [15:0] RST_LED2       = 16'h0008;
  localparam logic [15:0] RST_LED3       = 16'h0090;
  localparam logic [15:0] RST_ZERO       = 16'h0000;

  // field positions of the miscellaneous configuration register
  localparam int unsigned MODE_BIT       = 15;
  localparam int unsigned TP_LOOP_BIT    = 14;
  localparam int unsigned RSVD_BIT       = 13;
  localparam int unsigned SLOT_BIT       = 12;
  localparam int unsigned GUARD_BIT      = 11;
  localparam int unsigned ID_DEC_BIT     = 10;
  localparam int unsigned ACTIVATE_BIT   = 9;
  localparam int unsigned PROM_WE_BIT    = 8;
  localparam int unsigned EAD_SEL_BIT    = 3;
  // bits that software may change in the miscellaneous register
  localparam logic [15:0] MISC_WR_MASK   = 16'h4FFF;

  // product identifier window, 12-bit decode, four bytes
  localparam logic [11:0] ID_BASE_ADDR   = 12'hC80;
  localparam int unsigned ID_ADDR_LSB    = 2;

  // autoconfiguration sequencer states
  typedef enum logic [3:0] {
    AC_WAIT     = 4'b0001,
    AC_INACTIVE = 4'b0010,
    AC_ACTIVE   = 4'b0100,
    AC_ALTERNATE = 4'b1000
  } autoconfig_state_t;

  // reset value of a bank entry by index
  function automatic logic [15:0] cfg_default(input logic [6:0] idx);
    case (idx)
      IDX_MSRDA: cfg_default = RST_MSRDA;
      IDX_MSWRA: cfg_default = RST_MSWRA;
      IDX_MISC:  cfg_default = RST_MISC;
      IDX_LED0:  cfg_default = RST_LED0;
      IDX_LED1:  cfg_default = RST_LED1;
      IDX_LED2:  cfg_default = RST_LED2;
      IDX_LED3:  cfg_default = RST_LED3;
      default:   cfg_default = RST_ZERO;
    endcase
  endfunction

  // true when an index falls inside the bank
  function automatic logic in_bank(input logic [6:0] idx);
    in_bank = (idx <= IDX_CFG_LAST);
  endfunction

endpackage

// ===== rtl/misc_config_register.sv
`timescale 1ns/1ps
`default_nettype none
module misc_config_register
  import misc_cfg_pkg::*;
(
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // register index port and data port
  input  wire logic             index_wr_i,
  input  wire logic             data_wr_i,
  input  wire logic             data_rd_i,
  input  wire logic [15:0]      wdata_i,
  input  wire logic             sw_reset_rd_i,
  output logic [15:0]           rdata_o,
  output logic                  rdata_valid_o,
  // hardware state reported in the register
  input  wire logic             shared_mem_mode_i,
  input  wire logic             slot_8bit_i,
  input  wire logic             init_done_i,
  // loopback context
  input  wire logic             tp_selected_i,
  input  wire logic             ext_loopback_i,
  output logic                  tp_board_loop_o,
  output logic                  tp_ext_loop_allowed_o,
  // product identifier decode
  input  wire logic             io_cycle_i,
  input  wire logic [11:0]      io_addr_i,
  output logic                  id_decode_hit_o,
  // eeprom driven activation
  input  wire logic             eeprom_done_i,
  input  wire logic             eeprom_cksum_ok_i,
  output logic                  controller_active_o,
  output logic                  alt_access_o,
  // station prom and flash write gating
  input  wire logic             prom_wr_req_i,
  input  wire logic             flash_wr_req_i,
  output logic                  prom_wr_o,
  output logic                  flash_wr_o,
  // indicator outputs
  input  wire logic             tp_link_i,
  input  wire logic [2:0]       led_normal_i,
  input  wire logic [2:0]       ead_func_i,
  output logic [3:0]            led_o,
  output logic                  config_write_guard_o
);

  // ---- state declarations

  logic [IDX_W-1:0]  index_q;          // register index port
  logic [IDX_W-1:0]  index_d;
  logic [15:0]       cfg_q [NUM_CFG];  // configuration bank
  logic [15:0]       cfg_d [NUM_CFG];
  logic              slot_q;           // latched slot width
  logic              slot_d;
  logic [15:0]       rdata_q;          // read data holding
  logic [15:0]       rdata_d;
  logic              rvalid_q;         // read answer marker
  logic              rvalid_d;

  // registered side outputs
  logic              tp_loop_q;
  logic              tp_loop_d;
  logic              tp_allow_q;
  logic              tp_allow_d;
  logic              id_hit_q;
  logic              id_hit_d;
  logic              active_q;
  logic              active_d;
  logic              alt_q;
  logic              alt_d;
  logic              prom_wr_q;
  logic              prom_wr_d;
  logic              flash_wr_q;
  logic              flash_wr_d;
  logic [3:0]        led_q;
  logic [3:0]        led_d;
  logic              guard_q;
  logic              guard_d;

  // ---- decoded fields of the miscellaneous register

  logic [15:0]       misc_w;           // stored miscellaneous word
  logic              tp_loop_en_w;     // twisted pair board loop
  logic              guard_w;          // config write guard
  logic              id_dec_en_w;      // extended id decode enable
  logic              activate_w;       // autoconfig activate
  logic              prom_we_w;        // station prom write enable
  logic              ead_sel_w;        // external address detect

  // ---- helper results from the sub-blocks

  logic [NUM_CFG-1:0] wr_en_w;         // gated write enables
  logic               soft_clear_w;    // software reset accepted
  logic               seq_active_w;    // sequencer active flag
  logic               seq_alt_w;       // sequencer alternate flag

  // field extraction from the stored word
  assign misc_w       = cfg_q[IDX_MISC[2:0]];
  assign tp_loop_en_w = misc_w[TP_LOOP_BIT];
  assign guard_w      = misc_w[GUARD_BIT];
  assign id_dec_en_w  = misc_w[ID_DEC_BIT];
  assign activate_w   = misc_w[ACTIVATE_BIT];
  assign prom_we_w    = misc_w[PROM_WE_BIT];
  assign ead_sel_w    = misc_w[EAD_SEL_BIT];

  // ---- sub-block instances

  // write gating and software reset acceptance
  config_write_gate u_gate (
    .index_i       (index_q),
    .data_wr_i     (data_wr_i),
    .sw_reset_rd_i (sw_reset_rd_i),
    .guard_i       (guard_w),
    .wr_en_o       (wr_en_w),
    .soft_clear_o  (soft_clear_w)
  );

  // activation after the serial eeprom read
  autoconfig_sequencer u_seq (
    .clock_i           (clock_i),
    .rst_i             (rst_i),
    .eeprom_done_i     (eeprom_done_i),
    .eeprom_cksum_ok_i (eeprom_cksum_ok_i),
    .activate_i        (activate_w),
    .active_o          (seq_active_w),
    .alternate_o       (seq_alt_w)
  );

  // ---- index port and bank

  // next values of the index and the bank entries
  always_comb begin
    index_d = index_q;
    if (index_wr_i) begin
      index_d = wdata_i[IDX_W-1:0];
    end
    for (int i = 0; i < NUM_CFG; i++) begin
      cfg_d[i] = cfg_q[i];
      if (soft_clear_w) begin
        // software reset read restores the whole bank
        cfg_d[i] = cfg_default(7'(i));
      end else if (wr_en_w[i]) begin
        if (i == int'(IDX_MISC)) begin
          // read-only and reserved bits keep their value
          cfg_d[i] = (wdata_i & MISC_WR_MASK) |
                     (cfg_q[i] & ~MISC_WR_MASK);
        end else begin
          cfg_d[i] = wdata_i;
        end
      end
    end
  end

  // index and bank registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      index_q <= '0;
      cfg_q[0] <= RST_MSRDA;
      cfg_q[1] <= RST_MSWRA;
      cfg_q[2] <= RST_MISC;
      cfg_q[3] <= RST_ZERO;
      cfg_q[4] <= RST_LED0;
      cfg_q[5] <= RST_LED1;
      cfg_q[6] <= RST_LED2;
      cfg_q[7] <= RST_LED3;
    end else begin
      index_q <= index_d;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // ---- slot width capture

  // follow the strap only until the initialize bit is set
  always_comb begin
    slot_d = slot_q;
    if (!init_done_i) begin
      slot_d = slot_8bit_i;
    end
  end

  // slot width holding register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      slot_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
    end
  end

  // ---- read path

  // one-cycle read answer through the data port
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = data_rd_i;
    if (data_rd_i) begin
      if (index_q == IDX_MISC) begin
        rdata_d = misc_w;
        rdata_d[MODE_BIT] = shared_mem_mode_i;
        rdata_d[RSVD_BIT] = 1'b0;
        rdata_d[SLOT_BIT] = slot_q;
      end else if (in_bank(index_q) && index_q != IDX_EECFG) begin
        rdata_d = cfg_q[index_q[2:0]];
      end else begin
        // indices outside this bank answer zero
        rdata_d = RST_ZERO;
      end
    end
  end

  // read data registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q  <= RST_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ---- functions steered by the register

  // loopback, decode, write gating and indicator muxing
  always_comb begin
    // clip loop only in twisted pair external loopback
    tp_loop_d  = tp_loop_en_w && tp_selected_i &&
                 ext_loopback_i;
    // ordinary external loop stays allowed when clear
    tp_allow_d = !tp_loop_en_w && tp_selected_i &&
                 ext_loopback_i;
    // four-byte product identifier window
    id_hit_d   = id_dec_en_w && io_cycle_i &&
                 (io_addr_i[11:ID_ADDR_LSB] ==
                  ID_BASE_ADDR[11:ID_ADDR_LSB]);
    // activation outcome of the sequencer
    active_d   = seq_active_w;
    alt_d      = seq_alt_w;
    // prom ram and flash share one write enable
    prom_wr_d  = prom_wr_req_i && prom_we_w;
    flash_wr_d = flash_wr_req_i && prom_we_w;
    // indicator zero always shows link
    led_d[0]   = tp_link_i;
    if (ead_sel_w) begin
      led_d[3:1] = ead_func_i;
    end else begin
      led_d[3:1] = led_normal_i;
    end
    guard_d    = guard_w;
  end

  // registered side outputs
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tp_loop_q  <= 1'b0;
      tp_allow_q <= 1'b0;
      id_hit_q   <= 1'b0;
      active_q   <= 1'b0;
      alt_q      <= 1'b0;
      prom_wr_q  <= 1'b0;
      flash_wr_q <= 1'b0;
      led_q      <= 4'h0;
      guard_q    <= 1'b0;
    end else begin
      tp_loop_q  <= tp_loop_d;
      tp_allow_q <= tp_allow_d;
      id_hit_q   <= id_hit_d;
      active_q   <= active_d;
      alt_q      <= alt_d;
      prom_wr_q  <= prom_wr_d;
      flash_wr_q <= flash_wr_d;
      led_q      <= led_d;
      guard_q    <= guard_d;
    end
  end

  // ---- output drive, all from flip-flops

  assign rdata_o               = rdata_q;
  assign rdata_valid_o         = rvalid_q;
  assign tp_board_loop_o       = tp_loop_q;
  assign tp_ext_loop_allowed_o = tp_allow_q;
  assign id_decode_hit_o       = id_hit_q;
  assign controller_active_o   = active_q;
  assign alt_access_o          = alt_q;
  assign prom_wr_o             = prom_wr_q;
  assign flash_wr_o            = flash_wr_q;
  assign led_o                 = led_q;
  assign config_write_guard_o  = guard_q;

endmodule
`default_nettype wire

// ===== testbench/misc_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module misc_cfg_checker (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // register port
  input wire logic        data_rd_i,
  input wire logic        rdata_valid_o,
  // loopback
  input wire logic        tp_selected_i,
  input wire logic        ext_loopback_i,
  input wire logic        tp_board_loop_o,
  input wire logic        tp_ext_loop_allowed_o,
  // id decode
  input wire logic        io_cycle_i,
  input wire logic [11:0] io_addr_i,
  input wire logic        id_decode_hit_o,
  // activation
  input wire logic        eeprom_done_i,
  input wire logic        eeprom_cksum_ok_i,
  input wire logic        controller_active_o,
  input wire logic        alt_access_o,
  // prom and flash gating
  input wire logic        prom_wr_req_i,
  input wire logic        flash_wr_req_i,
  input wire logic        prom_wr_o,
  input wire logic        flash_wr_o,
  // indicators
  input wire logic        tp_link_i,
  input wire logic [3:0]  led_o
);
  // single clock domain, checks idle during reset
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  read_answer_a: assert property (data_rd_i |=> rdata_valid_o)
    else $error("read not answered next cycle");
  board_ctx_a: assert property (tp_board_loop_o |->
    $past(tp_selected_i && ext_loopback_i))
    else $error("board loop without context");
  loop_excl_a: assert property (!(tp_board_loop_o &&
    tp_ext_loop_allowed_o)) else $error("both loop modes at once");
  // flops still sit in reset at the release edge, so skip that attempt
  loop_cover_a: assert property (
    !rst_i && tp_selected_i && ext_loopback_i |=>
    tp_board_loop_o || tp_ext_loop_allowed_o)
    else $error("no loop mode in loop context");
  id_window_a: assert property (id_decode_hit_o |->
    $past(io_cycle_i && io_addr_i[11:2] == 10'h320))
    else $error("id hit outside window");
  prom_gate_a: assert property (prom_wr_o |->
    $past(prom_wr_req_i)) else $error("prom write without request");
  flash_same_a: assert property (
    prom_wr_req_i && flash_wr_req_i |=> prom_wr_o == flash_wr_o)
    else $error("flash and prom gate differ");
  led_link_a: assert property (!rst_i |=>
    led_o[0] == $past(tp_link_i)) else $error("first indicator not link");
  one_outcome_a: assert property (
    !(controller_active_o && alt_access_o))
    else $error("active and alternate together");
  active_time_a: assert property ($rose(controller_active_o) |->
    $past(eeprom_done_i, 2) && $past(eeprom_cksum_ok_i, 2))
    else $error("activation not from good eeprom read");
  alt_time_a: assert property ($rose(alt_access_o) |->
    $past(eeprom_done_i, 2) && !$past(eeprom_cksum_ok_i, 2))
    else $error("alternate not from bad checksum");
endmodule

bind misc_config_register misc_cfg_checker chk (
  .clock_i, .rst_i, .data_rd_i, .rdata_valid_o, .tp_selected_i,
  .ext_loopback_i, .tp_board_loop_o, .tp_ext_loop_allowed_o, .io_cycle_i,
  .io_addr_i, .id_decode_hit_o, .eeprom_done_i, .eeprom_cksum_ok_i,
  .controller_active_o, .alt_access_o, .prom_wr_req_i, .flash_wr_req_i,
  .prom_wr_o, .flash_wr_o, .tp_link_i, .led_o
);
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import misc_cfg_pkg::*;
;
  // design inputs
  logic        clock_i, rst_i, index_wr_i, data_wr_i, data_rd_i;
  logic        sw_reset_rd_i, shared_mem_mode_i, slot_8bit_i, init_done_i;
  logic        tp_selected_i, ext_loopback_i, io_cycle_i, eeprom_done_i;
  logic        eeprom_cksum_ok_i, prom_wr_req_i, flash_wr_req_i, tp_link_i;
  logic [15:0] wdata_i;
  logic [11:0] io_addr_i;
  logic [2:0]  led_normal_i, ead_func_i;
  // design outputs
  logic [15:0] rdata_o;
  logic [3:0]  led_o;
  logic        rdata_valid_o, tp_board_loop_o, tp_ext_loop_allowed_o;
  logic        id_decode_hit_o, controller_active_o, alt_access_o;
  logic        prom_wr_o, flash_wr_o, config_write_guard_o;
  // bookkeeping
  int          fail_count = 0;
  int          checked    = 0;

  misc_config_register dut (
    .clock_i, .rst_i, .index_wr_i, .data_wr_i, .data_rd_i, .wdata_i,
    .sw_reset_rd_i, .rdata_o, .rdata_valid_o, .shared_mem_mode_i,
    .slot_8bit_i, .init_done_i, .tp_selected_i, .ext_loopback_i,
    .tp_board_loop_o, .tp_ext_loop_allowed_o, .io_cycle_i, .io_addr_i,
    .id_decode_hit_o, .eeprom_done_i, .eeprom_cksum_ok_i,
    .controller_active_o, .alt_access_o, .prom_wr_req_i, .flash_wr_req_i,
    .prom_wr_o, .flash_wr_o, .tp_link_i, .led_normal_i, .ead_func_i,
    .led_o, .config_write_guard_o
  );

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // side outputs packed for one compare
  function automatic logic [15:0] outs();
    return {6'h00, tp_board_loop_o, tp_ext_loop_allowed_o, id_decode_hit_o,
            prom_wr_o, flash_wr_o, config_write_guard_o, led_o};
  endfunction

  // activation outcome packed for one compare
  function automatic logic [15:0] seq_outs();
    return {14'h0000, controller_active_o, alt_access_o};
  endfunction

  // load the index port, one cycle
  task automatic set_idx(input logic [6:0] idx);
    @(posedge clock_i);
    index_wr_i <= 1'b1;
    wdata_i    <= {9'h000, idx};
    @(posedge clock_i);
    index_wr_i <= 1'b0;
  endtask

  // indexed write
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    set_idx(idx);
    data_wr_i <= 1'b1;
    wdata_i   <= d;
    @(posedge clock_i);
    data_wr_i <= 1'b0;
  endtask

  // indexed read, answer one cycle after the strobe
  task automatic rdc(input logic [6:0] idx, input logic [15:0] exp);
    set_idx(idx);
    data_rd_i <= 1'b1;
    @(posedge clock_i);
    data_rd_i <= 1'b0;
    #1;
    chk({15'h0000, rdata_valid_o}, 16'h0001);
    chk(rdata_o, exp);
  endtask

  // one read of the software reset location
  task automatic soft_reset;
    @(posedge clock_i);
    sw_reset_rd_i <= 1'b1;
    @(posedge clock_i);
    sw_reset_rd_i <= 1'b0;
  endtask

  // hardware reset for two cycles
  task automatic do_reset;
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
  endtask

  // every bank entry at its default
  task automatic t_defaults;
    logic [15:0] exp [8] = '{16'h0005, 16'h0005, 16'h0002, 16'h0000,
                             16'h0000, 16'h0084, 16'h0008, 16'h0090};
    for (int i = 0; i < 8; i++) begin
      rdc(i[6:0], exp[i]);
    end
    $display("test defaults done");
  endtask

  // field effects on loop, decode, gating and indicators
  task automatic t_fields;
    @(posedge clock_i);
    shared_mem_mode_i <= 1'b1;
    slot_8bit_i       <= 1'b1;
    wr(IDX_MISC, 16'h0000);
    rdc(IDX_MISC, 16'h9000);
    wr(IDX_MISC, 16'h4508);
    rdc(IDX_MISC, 16'hD508);
    @(posedge clock_i);
    tp_selected_i  <= 1'b1;
    ext_loopback_i <= 1'b1;
    io_cycle_i     <= 1'b1;
    io_addr_i      <= 12'hC83;
    prom_wr_req_i  <= 1'b1;
    flash_wr_req_i <= 1'b1;
    tp_link_i      <= 1'b1;
    led_normal_i   <= 3'h5;
    ead_func_i     <= 3'h2;
    @(posedge clock_i);
    #1;
    chk(outs(), 16'h02E5);
    @(posedge clock_i);
    tp_selected_i <= 1'b0;
    io_addr_i     <= 12'hC84;
    @(posedge clock_i);
    #1;
    chk(outs(), 16'h0065);
    wr(IDX_MISC, 16'h0000);
    tp_selected_i <= 1'b1;
    io_addr_i     <= 12'hC80;
    @(posedge clock_i);
    #1;
    chk(outs(), 16'h010B);
    $display("test fields done");
  endtask

  // guard blocks writes and the software reset
  task automatic t_guard;
    wr(IDX_MSRDA, 16'h000A);
    // guard plus prom write enable, both must drop on hardware reset
    wr(IDX_MISC, 16'h0900);
    wr(IDX_MSRDA, 16'h0003);
    wr(IDX_LED1, 16'h0000);
    wr(IDX_MISC, 16'h0000);
    soft_reset;
    rdc(IDX_MSRDA, 16'h000A);
    rdc(IDX_LED1, 16'h0084);
    rdc(IDX_MISC, 16'h9900);
    chk({15'h0000, config_write_guard_o}, 16'h0001);
    do_reset;
    rdc(IDX_MISC, 16'h9002);
    $display("test guard done");
  endtask

  // unguarded software reset restores defaults
  task automatic t_soft;
    wr(IDX_LED3, 16'h0001);
    wr(IDX_MISC, 16'h0100);
    rdc(IDX_LED3, 16'h0001);
    soft_reset;
    rdc(IDX_LED3, 16'h0090);
    rdc(IDX_MISC, 16'h9002);
    $display("test soft reset done");
  endtask

  // slot width follows the pin until initialize
  task automatic t_slot;
    @(posedge clock_i);
    slot_8bit_i <= 1'b0;
    rdc(IDX_MISC, 16'h8002);
    @(posedge clock_i);
    slot_8bit_i <= 1'b1;
    rdc(IDX_MISC, 16'h9002);
    @(posedge clock_i);
    init_done_i <= 1'b1;
    @(posedge clock_i);
    slot_8bit_i <= 1'b0;
    rdc(IDX_MISC, 16'h9002);
    $display("test slot done");
  endtask

  // activation outcomes: bad checksum, activate, idle
  task automatic t_seq;
    logic [3:0] cs [3] = '{4'b1001, 4'b1110, 4'b0100};
    for (int i = 0; i < 3; i++) begin
      do_reset;
      wr(IDX_MISC, {6'h00, cs[i][3], 9'h000});
      @(posedge clock_i);
      eeprom_done_i     <= 1'b1;
      eeprom_cksum_ok_i <= cs[i][2];
      @(posedge clock_i);
      eeprom_done_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      chk(seq_outs(), 16'(cs[i][1:0]));
      repeat (4) @(posedge clock_i);
      #1;
      chk(seq_outs(), 16'(cs[i][1:0]));
    end
    $display("test activation done");
  endtask

  // counts and verdict
  task automatic wrap_up;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    $display("timeout reached");
    wrap_up;
  end

  // main sequence
  initial begin
    {rst_i, index_wr_i, data_wr_i, data_rd_i, sw_reset_rd_i} = 5'b10000;
    {shared_mem_mode_i, slot_8bit_i, init_done_i, tp_selected_i} = 4'h0;
    {ext_loopback_i, io_cycle_i, eeprom_done_i, eeprom_cksum_ok_i} = 4'h0;
    {prom_wr_req_i, flash_wr_req_i, tp_link_i} = 3'h0;
    wdata_i      = 16'h0000;
    io_addr_i    = 12'h000;
    led_normal_i = 3'h0;
    ead_func_i   = 3'h0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    t_defaults;
    t_fields;
    t_guard;
    t_soft;
    t_slot;
    t_seq;
    wrap_up;
  end
endmodule
`default_nettype wire
